// ---- src/orient_pkg.sv ----
// constants shared by the orientation and flat detector
package orient_pkg;
  // register offsets
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] ORIENT_CFG_OFS = 8'h65;
  localparam logic [7:0] FLAT_CFG_OFS = 8'h67;
  // orientation config fields
  localparam int OC_MODE_LSB = 0;
  localparam int OC_BLOCK_LSB = 2;
  localparam int OC_HYST_LSB = 4;
  localparam int OC_THETA_LSB = 8;
  localparam int OC_FACE_BIT = 14;
  localparam int OC_SWAP_BIT = 15;
  // flat config fields
  localparam int FC_THETA_LSB = 0;
  localparam int FC_HYST_LSB = 8;
  localparam int FC_HOLD_LSB = 12;
  // reset values
  localparam logic [15:0] ORIENT_CFG_RST = 16'h0000;
  localparam logic [15:0] FLAT_CFG_RST = 16'h0000;
  // status fields
  localparam int ST_ORIENT_LSB = 24;
  localparam int ST_FLAT_BIT = 27;
  // fixed thresholds in 2g scale on 8-bit data (1g = 64)
  localparam logic [7:0] FACE_HYST_8 = 8'h0D; // ~200 mg
  localparam logic [7:0] HIGH_G_8 = 8'h60; // 1.5g
  localparam logic [7:0] SLOPE_LO_8 = 8'h0D; // 0.2g
  localparam logic [7:0] SLOPE_HI_8 = 8'h1A; // 0.4g
  localparam int SLOPE_RUN = 3;
  // stability timer, in samples at the sample rate
  localparam int STABLE_MS = 100;
  localparam int SAMPLE_HZ = 100;
  localparam int STABLE_SAMPLES = (STABLE_MS * SAMPLE_HZ) / 1000;
  // orientation modes
  typedef enum logic [1:0] {
    MODE_SYM0 = 2'b00,
    MODE_HIGH = 2'b01,
    MODE_LOW = 2'b10,
    MODE_SYM1 = 2'b11
  } orient_mode_e;
endpackage

// ---- src/axis_sat_if.sv ----
// interface between the top and the saturation/square unit
`timescale 1ns/1ns
interface axis_sat_if;
  logic [7:0] ax;
  logic [7:0] ay;
  logic [7:0] az;
  logic [9:0] xy_sum;
  logic [5:0] z_sq6;
  modport top (output ax, output ay, output az, input xy_sum, input z_sq6);
  modport unit (input ax, input ay, input az, output xy_sum, output z_sq6);
endinterface

// ---- src/axis_sat_unit.sv ----
// saturated squares for horizontal and flat tests
`timescale 1ns/1ns
module axis_sat_unit (
  // operands and results
  axis_sat_if.unit s
);
  // absolute 8-bit value reduced to 6 bits, clamped at 1g
  function automatic logic [5:0] sat6(input logic [7:0] v);
    logic [7:0] a;
    a = v[7] ? 8'(-v) : v;
    if (a[7] || a[6]) begin
      sat6 = 6'h3F;
    end else begin
      sat6 = a[5:0];
    end
  endfunction
  // squares kept to the 10 upper bits
  function automatic logic [9:0] sq10(input logic [5:0] v);
    logic [11:0] p;
    p = {6'h00, v} * {6'h00, v};
    sq10 = p[11:2];
  endfunction
  logic [10:0] sum11;
  logic [9:0] zsq;
  always_comb begin
    sum11 = {1'b0, sq10(sat6(s.ax))} + {1'b0, sq10(sat6(s.ay))};
    zsq = sq10(sat6(s.az));
  end
  assign s.xy_sum = sum11[10] ? 10'h3FF : sum11[9:0];
  assign s.z_sq6 = zsq[9:4];
endmodule

// ---- src/orientation_flat_detector.sv ----
// orientation and flat detector on the accelerometer sample stream
// How it works
// - high-asymmetric mode uses factor two bounds
// - low-asymmetric mode uses factor half bounds
// - face hysteresis 200 mg, scaled by range
// - face bit 0 above +200mg, 1 below -200mg
// - blocking 00 none, 01 horizontal or 1.5g
// - blocking 10 adds slope over 0.2g
// - blocking 11 adds 0.4g slope and 100ms
// - slope block released after three quiet samples
// - change restarts 100 ms stability timer
// - horizontal when theta times z squared exceeds
// - saturated axis: 6 bits, clamp 1g
// - rescale other ranges to 2g scale
// - interrupt on every orientation code change except the bit2 clear when face is disabled
// - face disabled: bits 1:0 only, bit2 zero
// - status fields updated on interrupt condition
// - axis swap exchanges x and z here only
// - flat set when product minus hysteresis covers
// - flat cleared when product plus hysteresis below
// - still flag false after three large slopes, blocking 10/11 only
// - flat holds for hold time before interrupt
// - flat interrupt on entering and leaving
// - mode 00/11 symmetric, 01 high, 10 low
// - symmetric mode compares y with x
// - engine works on 8-bit samples
`timescale 1ns/1ns
module orientation_flat_detector
#(
  parameter int HOLD_UNIT = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // sample stream, 16-bit signed per axis
  input wire logic sample_valid,
  input wire logic [15:0] acc_x,
  input wire logic [15:0] acc_y,
  input wire logic [15:0] acc_z,
  input wire logic [1:0] range_sel,
  input wire logic latched,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // events
  output logic orient_irq,
  output logic flat_irq
);
  import orient_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] orient_cfg_r;
  logic [15:0] flat_cfg_r;
  logic [2:0] orient_r;
  logic flat_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      orient_cfg_r <= ORIENT_CFG_RST;
      flat_cfg_r <= FLAT_CFG_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == ORIENT_CFG_OFS) begin
        orient_cfg_r <= reg_wdata;
      end
      if (reg_addr == FLAT_CFG_OFS) begin
        flat_cfg_r <= reg_wdata;
      end
    end
  end

  // read mux, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      unique case (reg_addr)
        STATUS_OFS: reg_rdata <= {4'h0, flat_r, orient_r, 24'h000000};
        ORIENT_CFG_OFS: reg_rdata <= {16'h0000, orient_cfg_r};
        FLAT_CFG_OFS: reg_rdata <= {16'h0000, flat_cfg_r};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // config fields
  orient_mode_e mode;
  logic [1:0] blk_sel;
  logic [3:0] pl_hyst;
  logic [5:0] theta_blk;
  logic face_bit_irq_en;
  logic axis_swap_en;
  logic [5:0] theta_flat;
  logic [3:0] horizontal_hysteresis;
  logic [3:0] hold_sel;
  assign mode = orient_mode_e'(orient_cfg_r[OC_MODE_LSB +: 2]);
  assign blk_sel = orient_cfg_r[OC_BLOCK_LSB +: 2];
  assign pl_hyst = orient_cfg_r[OC_HYST_LSB +: 4];
  assign theta_blk = orient_cfg_r[OC_THETA_LSB +: 6];
  assign face_bit_irq_en = orient_cfg_r[OC_FACE_BIT];
  assign axis_swap_en = orient_cfg_r[OC_SWAP_BIT];
  assign theta_flat = flat_cfg_r[FC_THETA_LSB +: 6];
  assign horizontal_hysteresis = flat_cfg_r[FC_HYST_LSB +: 4];
  assign hold_sel = flat_cfg_r[FC_HOLD_LSB +: 4];

  // ------------------------------------------------------------
  // sample scaling and axis swap
  // ------------------------------------------------------------
  // 16-bit to 8-bit in 2g scale, saturating for wider ranges
  function automatic logic [7:0] to8(input logic [15:0] v, input logic [1:0] rs);
    logic [18:0] w;
    // one spare sign bit per shift step, so the 16g shift cannot lose the sign
    w = {{3{v[15]}}, v} <<< rs;
    if (w[18:15] != {4{w[18]}}) begin
      to8 = w[18] ? 8'h80 : 8'h7F;
    end else begin
      to8 = w[15:8];
    end
  endfunction
  function automatic logic [7:0] abs8(input logic [7:0] v);
    abs8 = v[7] ? ((v == 8'h80) ? 8'h7F : 8'(-v)) : v;
  endfunction

  logic [7:0] sx, sy, sz;
  always_comb begin
    sx = to8(acc_x, range_sel);
    sy = to8(acc_y, range_sel);
    sz = to8(acc_z, range_sel);
    if (axis_swap_en) begin
      // x<->z with z negated keeps right-handed frame
      sx = sz;
      sz = 8'(-to8(acc_x, range_sel));
    end
  end

  axis_sat_if sat ();
  assign sat.ax = sx;
  assign sat.ay = sy;
  assign sat.az = sz;
  axis_sat_unit u_sat (
    .s(sat)
  );

  // ------------------------------------------------------------
  // classification
  // ------------------------------------------------------------
  logic [8:0] ax9, ay9, hy9;
  logic land, port;
  logic [2:0] cand;
  always_comb begin
    ax9 = {1'b0, abs8(sx)};
    ay9 = {1'b0, abs8(sy)};
    hy9 = {5'h00, pl_hyst};
    unique case (mode)
      MODE_HIGH: begin
        land = ax9 > hy9 && ay9 < 9'((ax9 - hy9) << 1);
        port = {1'b0, ay9} > ({ax9, 1'b0} + {1'b0, hy9});
      end
      MODE_LOW: begin
        land = ax9 > hy9 && ay9 < ((ax9 - hy9) >> 1);
        port = ay9 > ((ax9 >> 1) + hy9);
      end
      MODE_SYM0, MODE_SYM1: begin
        land = ax9 > hy9 && ay9 < (ax9 - hy9);
        port = ay9 > (ax9 + hy9);
      end
    endcase
    cand = orient_r;
    if (land) begin
      cand[1:0] = sx[7] ? 2'b01 : 2'b00;
    end else if (port) begin
      cand[1:0] = sy[7] ? 2'b10 : 2'b11;
    end
    if (!sz[7] && sz > FACE_HYST_8) begin
      cand[2] = 1'b0;
    end else if (sz[7] && abs8(sz) > FACE_HYST_8) begin
      cand[2] = 1'b1;
    end
    if (!face_bit_irq_en) begin
      cand[2] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // blocking conditions
  // ------------------------------------------------------------
  logic [7:0] px_r, py_r, pz_r;
  logic [1:0] big_cnt_r, quiet_cnt_r;
  logic slope_blk_r;
  logic [7:0] slope_th;
  logic slope_big, high_g, near_hz;
  logic [11:0] th_prod;
  always_comb begin
    slope_th = (blk_sel == 2'b11) ? SLOPE_HI_8 : SLOPE_LO_8;
    slope_big = abs8(8'(sx - px_r)) > slope_th || abs8(8'(sy - py_r)) > slope_th ||
                abs8(8'(sz - pz_r)) > slope_th;
    high_g = abs8(sx) > HIGH_G_8 || abs8(sy) > HIGH_G_8 || abs8(sz) > HIGH_G_8;
    th_prod = {6'h00, theta_blk} * {6'h00, sat.z_sq6};
    near_hz = (th_prod[11:10] != 2'b00 ? 10'h3FF : th_prod[9:0]) > sat.xy_sum;
  end

  // slope runs: three large to block, three small to release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      px_r <= 8'h00;
      py_r <= 8'h00;
      pz_r <= 8'h00;
      big_cnt_r <= 2'b00;
      quiet_cnt_r <= 2'b00;
      slope_blk_r <= 1'b0;
    end else if (clk_en && sample_valid) begin
      px_r <= sx;
      py_r <= sy;
      pz_r <= sz;
      if (slope_big) begin
        quiet_cnt_r <= 2'b00;
        big_cnt_r <= (big_cnt_r == 2'(SLOPE_RUN)) ? big_cnt_r : big_cnt_r + 2'b01;
        if (big_cnt_r == 2'(SLOPE_RUN - 1)) begin
          slope_blk_r <= 1'b1;
        end
      end else begin
        big_cnt_r <= 2'b00;
        quiet_cnt_r <= (quiet_cnt_r == 2'(SLOPE_RUN)) ? quiet_cnt_r : quiet_cnt_r + 2'b01;
        if (quiet_cnt_r == 2'(SLOPE_RUN - 1)) begin
          slope_blk_r <= 1'b0;
        end
      end
    end
  end

  // stability timer in samples
  logic [7:0] stab_cnt_r;
  logic [2:0] last_cand_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stab_cnt_r <= 8'h00;
      last_cand_r <= 3'b000;
    end else if (clk_en && sample_valid) begin
      last_cand_r <= cand;
      if (cand != last_cand_r || high_g) begin
        stab_cnt_r <= 8'(STABLE_SAMPLES);
      end else if (stab_cnt_r != 8'h00) begin
        stab_cnt_r <= stab_cnt_r - 8'h01;
      end
    end
  end

  logic blocked;
  always_comb begin
    unique case (blk_sel)
      2'b00: blocked = 1'b0;
      2'b01: blocked = near_hz || high_g;
      2'b10: blocked = near_hz || high_g || slope_blk_r;
      2'b11: blocked = near_hz || high_g || slope_blk_r ||
                         cand != last_cand_r || stab_cnt_r > 8'h01;
    endcase
  end

  // ------------------------------------------------------------
  // orientation status and event
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      orient_r <= 3'b000;
      orient_irq <= 1'b0;
    end else if (clk_en) begin
      orient_irq <= 1'b0;
      if (!face_bit_irq_en) begin
        orient_r[2] <= 1'b0;
      end
      if (sample_valid && !blocked && cand != orient_r) begin
        orient_r <= cand;
        orient_irq <= (cand[1:0] != orient_r[1:0]) || face_bit_irq_en;
      end
    end
  end

  // ------------------------------------------------------------
  // flat detection
  // ------------------------------------------------------------
  logic still;
  logic [11:0] fl_prod;
  logic [10:0] fl_base, fl_hi;
  logic flat_on, flat_off;
  always_comb begin
    still = !(blk_sel[1] && slope_blk_r);
    fl_prod = {6'h00, theta_flat} * {6'h00, sat.z_sq6};
    fl_base = {1'b0, (fl_prod[11:10] != 2'b00) ? 10'h3FF : fl_prod[9:0]};
    fl_hi = fl_base + {7'h00, horizontal_hysteresis};
    flat_on = fl_base >= {7'h00, horizontal_hysteresis} &&
              (fl_base - {7'h00, horizontal_hysteresis}) >= {1'b0, sat.xy_sum} && still;
    flat_off = fl_hi < {1'b0, sat.xy_sum} || !still;
  end

  logic flat_raw_r;
  logic [11:0] hold_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flat_raw_r <= 1'b0;
      hold_cnt_r <= 12'h000;
      flat_r <= 1'b0;
      flat_irq <= 1'b0;
    end else if (clk_en) begin
      flat_irq <= 1'b0;
      if (sample_valid) begin
        if (flat_on) begin
          flat_raw_r <= 1'b1;
        end else if (flat_off && !latched) begin
          flat_raw_r <= 1'b0;
        end
        if ((flat_raw_r != flat_r)) begin
          if (hold_cnt_r >= 12'(hold_sel * HOLD_UNIT)) begin
            flat_r <= flat_raw_r;
            flat_irq <= 1'b1;
            hold_cnt_r <= 12'h000;
          end else begin
            hold_cnt_r <= hold_cnt_r + 12'h001;
          end
        end else begin
          hold_cnt_r <= 12'h000;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_face_zero_off: assert property (@(posedge clk) disable iff (!rst_n)
    !face_bit_irq_en && clk_en |=> !orient_r[2]) else $error("face bit set while disabled");
  a_irq_on_change: assert property (@(posedge clk) disable iff (!rst_n)
    $past(clk_en) && orient_irq |-> orient_r != $past(orient_r))
    else $error("irq without code change");
  a_no_block_00: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sample_valid && blk_sel == 2'b00 && cand[1:0] != orient_r[1:0]
    |=> orient_irq) else $error("event suppressed with blocking off");
  a_flat_irq_edge: assert property (@(posedge clk) disable iff (!rst_n)
    $past(clk_en) && flat_irq |-> flat_r != $past(flat_r)) else $error("flat irq without change");
  a_hold_before: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(flat_r) |-> $past(hold_cnt_r) >= 12'(hold_sel * HOLD_UNIT)) else $error("hold short");
  a_blk01_hg: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sample_valid && blk_sel == 2'b01 && high_g |=> !orient_irq)
    else $error("high g not blocking");
  a_slope_block: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(slope_blk_r) |-> $past(big_cnt_r) == 2'(SLOPE_RUN - 1)) else $error("slope run");
  a_still_flat: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sample_valid && !still && !latched |=> !flat_raw_r) else $error("flat moving");
endmodule

// ---- tb/orientation_flat_detector_tb.sv ----
// self-checking bench for the orientation and flat detector
`timescale 1ns/1ns
module orientation_flat_detector_tb;
  import orient_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic latched = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] acc_x = 16'h0000;
  logic [15:0] acc_y = 16'h0000;
  logic [15:0] acc_z = 16'h0000;
  logic [1:0] range_sel = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [31:0] reg_rdata;
  logic orient_irq;
  logic flat_irq;
  logic [31:0] o_tot = 32'h0;
  logic [31:0] f_tot = 32'h0;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [31:0] o0;
  logic [31:0] f0;
  // hold scaled down so flat hold steps are single samples
  orientation_flat_detector #(.HOLD_UNIT(1)) DUT (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sample_valid(sample_valid),
    .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .range_sel(range_sel),
    .latched(latched), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .orient_irq(orient_irq), .flat_irq(flat_irq)
  );
  // ----------------------------------------
  // clock, event counters and hang guard
  // ----------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (orient_irq === 1'b1) o_tot <= o_tot + 32'h1;
    if (flat_irq === 1'b1) f_tot <= f_tot + 32'h1;
    if (cyc == 10000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask
  // read data is registered one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) #1;
    reg_addr = a;
    @(posedge clk) #1;
    v = reg_rdata;
  endtask
  // one sample in 8-bit 2g scale, then a quiet gap that catches the pulses
  task automatic send(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    @(posedge clk) #1;
    acc_x = {x, 8'h00};
    acc_y = {y, 8'h00};
    acc_z = {z, 8'h00};
    sample_valid = 1'b1;
    @(posedge clk) #1;
    sample_valid = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] oc(int m, int b, int th, int fc, int sw);
    return 16'((m << OC_MODE_LSB) | (b << OC_BLOCK_LSB) | (th << OC_THETA_LSB)
      | (fc << OC_FACE_BIT) | (sw << OC_SWAP_BIT));
  endfunction
  // program, send one sample, check the event count and the status code
  task automatic step(input logic [15:0] cfg, input logic [7:0] x, input logic [7:0] y,
                      input logic [7:0] z, input logic irq, input logic [2:0] code);
    wr(ORIENT_CFG_OFS, cfg);
    o0 = o_tot;
    send(x, y, z);
    chk_reg(o_tot - o0, {31'h0, irq});
    rd(STATUS_OFS, d);
    chk_reg({29'h0, d[26:24]}, {29'h0, code});
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(ORIENT_CFG_OFS, d);
    chk_reg(d, {16'h0, ORIENT_CFG_RST});
    rd(FLAT_CFG_OFS, d);
    chk_reg(d, {16'h0, FLAT_CFG_RST});
    rd(STATUS_OFS, d);
    chk_reg({28'h0, d[27:24]}, 32'h0);
    wr(ORIENT_CFG_OFS, 16'hABCD);
    rd(ORIENT_CFG_OFS, d);
    chk_reg(d, 32'h0000ABCD);
    wr(8'h40, 16'h1234);
    rd(8'h40, d);
    chk_reg(d, 32'h0);
    $display("test registers done");
    step(oc(0, 0, 0, 1, 0), 8'h00, 8'h40, 8'h00, 1'b1, 3'h3);
    step(oc(0, 0, 0, 1, 0), 8'h00, 8'hC0, 8'h00, 1'b1, 3'h2);
    step(oc(0, 0, 0, 1, 0), 8'hC0, 8'h00, 8'h00, 1'b1, 3'h1);
    step(oc(0, 0, 0, 1, 0), 8'h28, 8'h28, 8'h00, 1'b0, 3'h1);
    step(oc(0, 0, 0, 1, 0), 8'h40, 8'h00, 8'h00, 1'b1, 3'h0);
    step(oc(0, 0, 0, 1, 0), 8'h40, 8'h00, 8'hC0, 1'b1, 3'h4);
    step(oc(0, 0, 0, 1, 0), 8'h40, 8'h00, 8'h08, 1'b0, 3'h4);
    step(oc(0, 0, 0, 1, 0), 8'h40, 8'h00, 8'h40, 1'b1, 3'h0);
    // hysteresis 8: y=52 against x=48 stays inside the band
    step(oc(0, 0, 0, 1, 0) | 16'(8 << OC_HYST_LSB), 8'h30, 8'h34, 8'h00, 1'b0, 3'h0);
    $display("test symmetrical done");
    step(oc(1, 0, 0, 1, 0), 8'h40, 8'h64, 8'h00, 1'b0, 3'h0);
    step(oc(1, 0, 0, 1, 0), 8'h1E, 8'h64, 8'h00, 1'b1, 3'h3);
    step(oc(1, 0, 0, 1, 0), 8'h40, 8'h50, 8'h00, 1'b1, 3'h0);
    step(oc(1, 0, 0, 1, 0), 8'h1E, 8'h64, 8'h00, 1'b1, 3'h3);
    step(oc(2, 0, 0, 1, 0), 8'h40, 8'h00, 8'h00, 1'b1, 3'h0);
    step(oc(2, 0, 0, 1, 0), 8'h40, 8'h28, 8'h00, 1'b1, 3'h3);
    step(oc(3, 0, 0, 1, 0), 8'h40, 8'h28, 8'h00, 1'b1, 3'h0);
    $display("test modes done");
    step(oc(0, 1, 0, 1, 0), 8'h9C, 8'h00, 8'h00, 1'b0, 3'h0);
    step(oc(0, 1, 0, 1, 0), 8'hC0, 8'h00, 8'h00, 1'b1, 3'h1);
    step(oc(0, 1, 63, 1, 0), 8'h00, 8'h10, 8'h40, 1'b0, 3'h1);
    step(oc(0, 0, 63, 1, 0), 8'h00, 8'h10, 8'h40, 1'b1, 3'h3);
    // slope block still set by the three large steps above
    step(oc(0, 2, 0, 1, 0), 8'h40, 8'h00, 8'h40, 1'b0, 3'h3);
    o0 = o_tot;
    repeat (3) send(8'h40, 8'h00, 8'h40);
    chk_reg(o_tot - o0, 32'h0);
    step(oc(0, 2, 0, 1, 0), 8'h40, 8'h00, 8'h40, 1'b1, 3'h0);
    step(oc(0, 2, 0, 1, 0), 8'h00, 8'h40, 8'h40, 1'b1, 3'h3);
    $display("test blocking done");
    step(oc(0, 0, 0, 0, 0), 8'h00, 8'h40, 8'hC0, 1'b0, 3'h3);
    step(oc(0, 0, 0, 1, 0), 8'h00, 8'h40, 8'h40, 1'b0, 3'h3);
    step(oc(0, 0, 0, 1, 1), 8'h00, 8'h0A, 8'h40, 1'b1, 3'h0);
    step(oc(0, 0, 0, 1, 0), 8'h00, 8'h0A, 8'h40, 1'b1, 3'h3);
    range_sel = 2'h1;
    step(oc(0, 0, 0, 1, 0), 8'hE0, 8'h00, 8'h00, 1'b1, 3'h1);
    range_sel = 2'h0;
    $display("test face swap range done");
    step(oc(0, 3, 0, 1, 0), 8'h40, 8'h00, 8'h00, 1'b0, 3'h1);
    step(oc(0, 3, 0, 1, 0), 8'h40, 8'h00, 8'h00, 1'b0, 3'h1);
    o0 = o_tot;
    repeat (12) send(8'h40, 8'h00, 8'h00);
    chk_reg(o_tot - o0, 32'h1);
    rd(STATUS_OFS, d);
    chk_reg({29'h0, d[26:24]}, 32'h0);
    $display("test stability done");
    wr(ORIENT_CFG_OFS, oc(0, 0, 0, 1, 0));
    wr(FLAT_CFG_OFS, 16'h403F);
    f0 = f_tot;
    repeat (2) send(8'h00, 8'h00, 8'h40);
    chk_reg(f_tot - f0, 32'h0);
    repeat (8) send(8'h00, 8'h00, 8'h40);
    chk_reg(f_tot - f0, 32'h1);
    rd(STATUS_OFS, d);
    chk_reg({31'h0, d[ST_FLAT_BIT]}, 32'h1);
    repeat (8) send(8'h40, 8'h00, 8'h00);
    chk_reg(f_tot - f0, 32'h2);
    rd(STATUS_OFS, d);
    chk_reg({31'h0, d[ST_FLAT_BIT]}, 32'h0);
    $display("test flat done");
    // latched: flat is entered but never left
    latched = 1'b1;
    repeat (6) send(8'h00, 8'h00, 8'h40);
    repeat (6) send(8'h40, 8'h00, 8'h00);
    chk_reg(f_tot - f0, 32'h3);
    rd(STATUS_OFS, d);
    chk_reg({31'h0, d[ST_FLAT_BIT]}, 32'h1);
    latched = 1'b0;
    // a sample offered while the enable is low is ignored
    clk_en = 1'b0;
    o0 = o_tot;
    send(8'h00, 8'h40, 8'h00);
    clk_en = 1'b1;
    chk_reg(o_tot - o0, 32'h0);
    rd(STATUS_OFS, d);
    chk_reg({29'h0, d[26:24]}, 32'h0);
    step(oc(0, 0, 0, 1, 0), 8'h00, 8'h40, 8'h00, 1'b1, 3'h3);
    $display("test latch freeze done");
    give_verdict();
  end
endmodule
